// ### hw/efd_cfg.svh
// Constants for the extended fault descriptor block
`ifndef EFD_CFG_SVH
`define EFD_CFG_SVH
`define EFD_BITS 64
`define EFD_WORD_W 16
`define EFD_MEM_DEPTH 16
`define EFD_OP_READ_MAINT 3'h6
`define EFD_MEM_FIRST 4'h3
`define EFD_WORDS 3'h4
`define EFD_B_CYL 1
`define EFD_B_SPARE 11
`define EFD_B_HEAD 13
`define EFD_B_SECT 16
`define EFD_B_OP 23
`define EFD_B_UNIT 26
`define EFD_B_VAR 29
`define EFD_B_MISS_RWCLK 34
`define EFD_B_MISS_AM 35
`define EFD_B_RD_DATA 36
`define EFD_B_NO_INDEX 37
`define EFD_B_CM_ERR 38
`define EFD_B_MSG 39
`define EFD_B_WP_WE 45
`define EFD_B_CM_SEEK 46
`define EFD_B_ILL_CYL 48
`define EFD_B_OFS_WE 50
`define EFD_B_OFS_SEEK 51
`define EFD_B_SEEK_INC 52
`define EFD_B_OFFTRK_WE 53
`define EFD_B_END_STOP 54
`define EFD_MSG_W 24
`define EFD_FLAG_W 32
`endif

// ### hw/efd_core.sv
// Extended fault descriptor: capture, message overlay, readout and copy
`include "efd_cfg.svh"

module efd_core #(
  parameter logic [2:0] RDM_OPCODE = `EFD_OP_READ_MAINT,
  parameter logic MODEL_FLAG = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Operation control
  input wire logic op_start,
  input wire logic op_end,
  input wire logic [2:0] opcode,
  input wire logic [2:0] unit,
  input wire logic [3:0] variant,
  input wire logic local_mode,
  input wire logic try_diag,
  // Address counter
  input wire logic [9:0] addr_cyl,
  input wire logic [2:0] addr_head,
  input wire logic [6:0] addr_sect,
  // Fault events
  input wire logic ev_missing_rw_clock,
  input wire logic ev_missing_addr_mark,
  input wire logic ev_read_data_missing,
  input wire logic ev_no_index,
  input wire logic ev_cm_error,
  input wire logic ev_offline,
  input wire logic seeking,
  input wire logic write_enable,
  input wire logic ev_write_protect,
  input wire logic ev_offset,
  input wire logic ev_off_track,
  input wire logic ev_illegal_cyl,
  input wire logic ev_seek_incomplete,
  input wire logic ev_end_stop,
  // Last controller message sent
  input wire logic cm_mark,
  input wire logic cm_write,
  input wire logic cm_read,
  input wire logic cm_addr_mark,
  input wire logic cm_continue,
  input wire logic cm_select,
  input wire logic [12:0] cm_payload,
  input wire logic cm_write_en,
  // Panel access to maintenance memory
  input wire logic panel_load,
  input wire logic [3:0] panel_addr,
  input wire logic [15:0] panel_data,
  input wire logic [3:0] panel_rd_addr,
  output logic [15:0] panel_rd_data,
  // Descriptor readout
  output logic [15:0] desc_word_one,
  output logic [15:0] desc_word_two,
  output logic [15:0] desc_word_three,
  output logic [15:0] desc_word_four,
  output logic desc_visible,
  output logic copy_busy,
  // Plug-on address indicator
  output logic [9:0] ind_cyl,
  output logic [2:0] ind_head,
  output logic [6:0] ind_sect,
  output logic [2:0] ind_unit
);
  // Vector index of descriptor bit n; bit 1 is index 63
  function automatic int dpos(input int n);
    return `EFD_BITS - n;
  endfunction

  // Word k (0 to 3) of the descriptor, word one in the high bits
  function automatic logic [15:0] dword(input efd_pkg::efd_desc_t d,
                                        input logic [1:0] k);
    return d[63 - 16 * k -: 16];
  endfunction

  efd_pkg::efd_desc_t desc_reg, desc_next;
  logic active_reg, active_next;
  logic cm_sub_reg, cm_sub_next;
  logic diag_reg, diag_next;
  efd_pkg::efd_state_t state_reg, state_next;
  logic [1:0] cnt_reg, cnt_next;
  logic [15:0] w1_reg, w2_reg, w3_reg, w4_reg;
  logic [9:0] icyl_reg;
  logic [2:0] ihead_reg, iunit_reg;
  logic [6:0] isect_reg;
  logic is_rdm, start_new, copy_go, watch;
  logic [`EFD_MSG_W-1:0] msg_vec;
  logic [21:0] msg_body;
  logic mem_we;
  logic [3:0] mem_waddr;
  logic [15:0] mem_wdata;

  assign is_rdm = opcode == RDM_OPCODE;
  assign start_new = op_start && !is_rdm;
  assign copy_go = op_start && is_rdm && variant[2] && local_mode &&
                   try_diag;
  assign watch = active_reg || start_new;

  // Message image, mark bit leftmost; parities even over their spans
  assign msg_body = {cm_mark, cm_write, cm_read, cm_addr_mark,
                     ^{cm_mark, cm_write, cm_read, cm_addr_mark},
                     cm_continue, cm_select, cm_payload, cm_write_en,
                     1'b0};
  assign msg_vec = {msg_body, ^msg_body, 1'b0};

  always_comb begin
    desc_next = desc_reg;
    active_next = active_reg;
    cm_sub_next = cm_sub_reg;
    diag_next = diag_reg;
    if (start_new) begin
      desc_next[dpos(`EFD_B_CM_ERR - 5):0] = '0;
      cm_sub_next = 1'b0;
      active_next = 1'b1;
      desc_next[dpos(`EFD_B_OP) -: 3] = opcode;
      desc_next[dpos(`EFD_B_UNIT) -: 3] = unit;
      desc_next[dpos(`EFD_B_VAR) -: 4] = {variant[0], variant[1],
                                          variant[2], variant[3]};
    end else if (active_reg && op_end) begin
      active_next = 1'b0;
    end
    if (op_start) begin
      diag_next = local_mode && try_diag;
    end
    if (watch) begin
      desc_next[dpos(`EFD_B_CYL) -: 10] = addr_cyl;
      desc_next[dpos(`EFD_B_HEAD) -: 3] = addr_head;
      desc_next[dpos(`EFD_B_SECT) -: 7] = addr_sect;
      desc_next[dpos(`EFD_B_MISS_RWCLK)] |= ev_missing_rw_clock;
      desc_next[dpos(`EFD_B_MISS_AM)] |= ev_missing_addr_mark;
      desc_next[dpos(`EFD_B_RD_DATA)] |= ev_read_data_missing;
      desc_next[dpos(`EFD_B_NO_INDEX)] |= ev_no_index;
      desc_next[dpos(`EFD_B_CM_ERR)] |= ev_cm_error;
      // A new operation drops the old overlay in its own start cycle
      if (!cm_sub_reg || start_new) begin
        desc_next[dpos(`EFD_B_MSG)] = MODEL_FLAG;
        desc_next[dpos(`EFD_B_WP_WE)] |=
          ev_write_protect && write_enable;
        desc_next[dpos(`EFD_B_CM_SEEK)] |=
          (ev_cm_error || ev_offline) && seeking;
        desc_next[dpos(`EFD_B_ILL_CYL)] |= ev_illegal_cyl;
        desc_next[dpos(`EFD_B_OFS_WE)] |=
          ev_offset && write_enable;
        desc_next[dpos(`EFD_B_OFS_SEEK)] |= ev_offset && seeking;
        desc_next[dpos(`EFD_B_SEEK_INC)] |= ev_seek_incomplete;
        desc_next[dpos(`EFD_B_OFFTRK_WE)] |=
          ev_off_track && write_enable;
        desc_next[dpos(`EFD_B_END_STOP)] |= ev_end_stop;
      end
      if (ev_cm_error && !local_mode) begin
        desc_next[dpos(`EFD_B_MSG) -: `EFD_MSG_W] = msg_vec;
        cm_sub_next = 1'b1;
      end
    end
    desc_next[dpos(`EFD_B_SPARE) -: 2] = 2'h0;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      desc_reg <= '0;
      active_reg <= 1'b0;
      cm_sub_reg <= 1'b0;
      diag_reg <= 1'b0;
    end else begin
      desc_reg <= desc_next;
      active_reg <= active_next;
      cm_sub_reg <= cm_sub_next;
      diag_reg <= diag_next;
    end
  end

  // Copy sequencer into maintenance memory
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      efd_pkg::EFD_IDLE: begin
        cnt_next = 2'h0;
        if (copy_go) begin
          state_next = efd_pkg::EFD_COPY;
        end
      end
      efd_pkg::EFD_COPY: begin
        cnt_next = cnt_reg + 2'h1;
        if (cnt_reg == 2'h3) begin
          state_next = efd_pkg::EFD_DONE;
        end
      end
      efd_pkg::EFD_DONE: begin
        state_next = efd_pkg::EFD_IDLE;
      end
      default: begin
        state_next = efd_pkg::EFD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= efd_pkg::EFD_IDLE;
      cnt_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  assign copy_busy = state_reg == efd_pkg::EFD_COPY;
  // Panel load is ignored while a copy owns the write port
  assign mem_we = copy_busy || panel_load;
  assign mem_waddr = copy_busy ? `EFD_MEM_FIRST + {2'h0, cnt_reg}
                               : panel_addr;
  assign mem_wdata = copy_busy ? dword(desc_reg, cnt_reg) : panel_data;

  efd_maint_mem #(
    .WIDTH(`EFD_WORD_W),
    .DEPTH(`EFD_MEM_DEPTH),
    .AW(4)
  ) u_mem (
    .clk(clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(panel_rd_addr),
    .rdata(panel_rd_data)
  );

  // Readout words and indicator registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      w1_reg <= 16'h0000;
      w2_reg <= 16'h0000;
      w3_reg <= 16'h0000;
      w4_reg <= 16'h0000;
      icyl_reg <= 10'h000;
      ihead_reg <= 3'h0;
      isect_reg <= 7'h00;
      iunit_reg <= 3'h0;
    end else begin
      w1_reg <= diag_next ? dword(desc_next, 2'h0) : 16'h0000;
      w2_reg <= diag_next ? dword(desc_next, 2'h1) : 16'h0000;
      w3_reg <= diag_next ? dword(desc_next, 2'h2) : 16'h0000;
      w4_reg <= diag_next ? dword(desc_next, 2'h3) : 16'h0000;
      icyl_reg <= addr_cyl;
      ihead_reg <= addr_head;
      isect_reg <= addr_sect;
      iunit_reg <= start_new ? unit : iunit_reg;
    end
  end

  assign desc_word_one = w1_reg;
  assign desc_word_two = w2_reg;
  assign desc_word_three = w3_reg;
  assign desc_word_four = w4_reg;
  assign desc_visible = diag_reg;
  assign ind_cyl = icyl_reg;
  assign ind_head = ihead_reg;
  assign ind_sect = isect_reg;
  assign ind_unit = iunit_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Flag region minus the model bit, which a new operation sets again
  a_flags_cleared: assert property (
    start_new && !ev_cm_error && !ev_offline && !ev_missing_rw_clock &&
    !ev_missing_addr_mark && !ev_read_data_missing && !ev_no_index &&
    !ev_illegal_cyl && !ev_seek_incomplete && !ev_end_stop && !ev_offset &&
    !ev_off_track && !ev_write_protect
    |=> desc_reg[dpos(`EFD_B_CM_ERR - 5):dpos(`EFD_B_CM_ERR)] == '0 &&
    desc_reg[dpos(`EFD_B_MSG + 1):0] == '0)
    else $error("flags not cleared at new operation");
  a_spares_zero: assert property (
    desc_reg[dpos(`EFD_B_SPARE) -: 2] == 2'h0)
    else $error("spare descriptor bits set");
  a_cm_overlay: assert property (
    watch && ev_cm_error && !local_mode
    |=> desc_reg[dpos(`EFD_B_MSG) -: `EFD_MSG_W] == $past(msg_vec))
    else $error("message not substituted");
  // Flags inside the message field are excluded while it is overwritten
  a_wp_flag: assert property (
    watch && ev_write_protect && write_enable && !cm_sub_reg &&
    !(ev_cm_error && !local_mode) |=> desc_reg[dpos(`EFD_B_WP_WE)] ##1
    (desc_reg[dpos(`EFD_B_WP_WE)] || $past(start_new) || cm_sub_reg))
    else $error("write protect flag lost");
  a_seek_flag: assert property (
    watch && ev_seek_incomplete && !cm_sub_reg &&
    !(ev_cm_error && !local_mode) |=> desc_reg[dpos(`EFD_B_SEEK_INC)])
    else $error("seek incomplete flag missing");
  a_clock_flag: assert property (
    watch && ev_missing_rw_clock |=> desc_reg[dpos(`EFD_B_MISS_RWCLK)])
    else $error("missing clock flag not set");
  a_seek_cm: assert property (
    watch && ev_offline && seeking && !cm_sub_reg &&
    !(ev_cm_error && !local_mode) |=> desc_reg[dpos(`EFD_B_CM_SEEK)])
    else $error("offline during seek not flagged");
  a_hold_idle: assert property (
    !active_reg && !op_start |=> $stable(desc_reg))
    else $error("descriptor changed while idle");
  a_copy_four: assert property (
    state_reg == efd_pkg::EFD_IDLE && copy_go
    |=> copy_busy [*4] ##1 !copy_busy)
    else $error("copy did not take four cycles");
  a_copy_addr: assert property (
    copy_busy && cnt_reg == 2'h0
    |-> mem_waddr == 4'h3 ##3 mem_waddr == 4'h6)
    else $error("copy address wrong");
  a_gate_diag: assert property (
    !desc_visible |-> desc_word_one == 16'h0000 &&
    desc_word_four == 16'h0000)
    else $error("descriptor shown without diagnostics");
  a_indicator: assert property (
    ##1 ind_cyl == $past(addr_cyl) && ind_sect == $past(addr_sect))
    else $error("indicator does not follow counter");

  c_copy: cover property (copy_go ##5 state_reg == efd_pkg::EFD_IDLE);
  c_overlay: cover property (watch && ev_cm_error && !local_mode);
  c_full_op: cover property (start_new ##[1:20] op_end);
endmodule

// ### hw/efd_maint_mem.sv
// Maintenance memory with one write port and a registered read port
module efd_maint_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ### hw/efd_pkg.sv
// Types for the extended fault descriptor block
package efd_pkg;
  typedef enum logic [1:0] {
    EFD_IDLE = 2'h0,
    EFD_COPY = 2'h1,
    EFD_DONE = 2'h3
  } efd_state_t;
  typedef logic [63:0] efd_desc_t;
endpackage

// ### tb/efd_far_end.sv
// Far-end model: drive fault events and operator panel loads
module efd_far_end (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bench requests
  input wire logic ev_go,
  input wire logic [3:0] ev_sel,
  input wire logic ld_go,
  input wire logic [10:0] ld_ctl,
  input wire logic [18:0] ld_addr,
  // Toward the block
  output logic [11:0] ev = 12'h000,
  output logic panel_load = 1'b0,
  output logic [3:0] panel_addr = 4'h0,
  output logic [15:0] panel_data = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ev_q = 1'b0;
  logic ld_q = 1'b0;
  logic ld_q2 = 1'b0;
  logic [3:0] sel_q = 4'h0;
  always @(posedge clk) begin
    ev_q <= ev_go & reset_n;
    sel_q <= ev_sel;
    ld_q <= ld_go;
    ld_q2 <= ld_q;
  end
  // Outputs move on the falling edge, clear of the sampling edge
  always @(negedge clk) begin
    ev <= ev_q ? 12'h001 << sel_q : 12'h000;
    panel_load <= ld_q | ld_q2;
    panel_addr <= {3'h0, ld_q2};
    if (ld_q)
      panel_data <= {ld_ctl, ld_addr[4:0]};
    else if (ld_q2)
      panel_data <= {2'h0, ld_addr[18:5]};
    else
      panel_data <= ~panel_data;
  end
endmodule

// ### tb/test_extended_fault_descriptor.sv
// Self-checking bench for the extended fault descriptor
module test_extended_fault_descriptor;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic op_start = 1'b0, op_end = 1'b0, local_mode = 1'b1, try_diag = 1'b1;
  logic seeking = 1'b0, write_enable = 1'b0, ev_go = 1'b0, ld_go = 1'b0;
  logic [2:0] opcode = 3'h0, unit = 3'h0, head = 3'h0;
  logic [3:0] variant = 4'h0, ev_sel = 4'h0, rd_addr = 4'h0;
  logic [9:0] cyl = 10'h000;
  logic [6:0] sect = 7'h00;
  logic [19:0] cm = 20'h00000;
  logic [10:0] ld_ctl = 11'h000;
  logic [18:0] ld_addr = 19'h00000;
  logic [2:0] ops [4] = '{3'h0, 3'h2, 3'h5, 3'h7};
  logic [3:0] vars [4] = '{4'h0, 4'h6, 4'h9, 4'hF};
  logic [11:0] ev;
  logic panel_load, copy_busy, desc_visible;
  logic [3:0] panel_addr;
  logic [15:0] panel_data, rd_data, m;
  logic [9:0] ind_cyl;
  logic [2:0] ind_head, ind_unit;
  logic [6:0] ind_sect;
  logic [63:0] desc, d;
  logic [22:0] ind;
  int errors = 0, n_tests = 0, cycles = 0, busy = 0;

  initial begin
    forever #50 clk = ~clk;
  end

  efd_far_end far (.clk, .reset_n, .ev_go, .ev_sel, .ld_go, .ld_ctl,
    .ld_addr, .ev, .panel_load, .panel_addr, .panel_data);

  efd_core dut (.clk, .reset_n, .op_start, .op_end, .opcode, .unit,
    .variant, .local_mode, .try_diag, .addr_cyl(cyl), .addr_head(head),
    .addr_sect(sect), .ev_missing_rw_clock(ev[0]),
    .ev_missing_addr_mark(ev[1]), .ev_read_data_missing(ev[2]),
    .ev_no_index(ev[3]), .ev_cm_error(ev[4]), .ev_offline(ev[5]),
    .seeking, .write_enable, .ev_write_protect(ev[6]), .ev_offset(ev[7]),
    .ev_off_track(ev[8]), .ev_illegal_cyl(ev[9]),
    .ev_seek_incomplete(ev[10]), .ev_end_stop(ev[11]), .cm_mark(cm[19]),
    .cm_write(cm[18]), .cm_read(cm[17]), .cm_addr_mark(cm[16]),
    .cm_continue(cm[15]), .cm_select(cm[14]), .cm_payload(cm[13:1]),
    .cm_write_en(cm[0]), .panel_load, .panel_addr, .panel_data,
    .panel_rd_addr(rd_addr), .panel_rd_data(rd_data),
    .desc_word_one(desc[63:48]), .desc_word_two(desc[47:32]),
    .desc_word_three(desc[31:16]), .desc_word_four(desc[15:0]),
    .desc_visible, .copy_busy, .ind_cyl, .ind_head, .ind_sect, .ind_unit);

  assign ind = {ind_cyl, ind_head, ind_sect, ind_unit};

  // Descriptor bit n (1 = leftmost) as a 64-bit mask
  function automatic logic [63:0] pos(input int b);
    return 64'h1 << (64 - b);
  endfunction

  function automatic logic [63:0] flag(input logic [3:0] s);
    case (s)
      4'h0: return pos(34);
      4'h1: return pos(35);
      4'h2: return pos(36);
      4'h3: return pos(37);
      4'h4: return pos(38) | (seeking ? pos(46) : 64'h0);
      4'h5: return seeking ? pos(46) : 64'h0;
      4'h6: return write_enable ? pos(45) : 64'h0;
      4'h7: return (write_enable ? pos(50) : 64'h0) |
        (seeking ? pos(51) : 64'h0);
      4'h8: return write_enable ? pos(53) : 64'h0;
      4'h9: return pos(48);
      4'hA: return pos(52);
      default: return pos(54);
    endcase
  endfunction

  function automatic logic [63:0] base();
    return {cyl, 2'h0, head, sect, opcode, unit, variant[0], variant[1],
      variant[2], variant[3], 6'h00, 1'b1, 25'h0000000};
  endfunction

  // Image of the last message as it lands in bits 39 to 62
  function automatic logic [23:0] msg(input logic [19:0] c);
    logic [23:0] r;
    r = {c[19:16], ^c[19:16], c[15:1], c[0], 3'h0};
    r[1] = ^r[23:2];
    return r;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic start(input logic [2:0] op, input logic [3:0] v,
    input logic lm, input logic td);
    opcode = op;
    variant = v;
    local_mode = lm;
    try_diag = td;
    op_start = 1'b1;
    tick(1);
    op_start = 1'b0;
    tick(2);
  endtask

  task automatic inject(input logic [3:0] s);
    ev_go = 1'b1;
    ev_sel = s;
    tick(1);
    ev_go = 1'b0;
    tick(3);
  endtask

  task automatic stop_op();
    op_end = 1'b1;
    tick(1);
    op_end = 1'b0;
    tick(1);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    rd_addr = a;
    tick(2);
    check({48'h0, rd_data}, {48'h0, e});
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(77350));
    tick(3);
    reset_n = 1'b1;
    tick(1);
    check(desc, 64'h0);
    for (int i = 0; i < 16; i++) begin
      cyl = 10'($urandom);
      head = 3'($urandom);
      sect = 7'($urandom);
      unit = 3'($urandom);
      seeking = 1'($urandom);
      write_enable = 1'($urandom);
      start(ops[i % 4], vars[$urandom % 4], 1'b1, 1'b1);
      d = base();
      check(desc, d);
      check(64'(desc_visible), 64'h1);
      check(64'(ind), 64'({cyl, head, sect, unit}));
      for (int k = 0; k < 2; k++) begin
        inject(4'((i + 5 * k) % 12));
        d = d | flag(4'((i + 5 * k) % 12));
      end
      check(desc, d);
      stop_op();
      inject(4'hA);
      check(desc, d);
    end
    start(3'h2, 4'h0, 1'b1, 1'b0);
    check(desc, 64'h0);
    check(64'(desc_visible), 64'h0);
    stop_op();
    seeking = 1'b1;
    cm = 20'($urandom);
    start(3'h2, 4'h0, 1'b0, 1'b1);
    check(desc, 64'h0);
    d = base() | pos(34) | pos(38);
    d[25:2] = msg(cm);
    inject(4'h0);
    inject(4'h4);
    inject(4'h9);
    stop_op();
    ld_ctl = 11'($urandom);
    ld_addr = 19'($urandom);
    ld_go = 1'b1;
    tick(1);
    ld_go = 1'b0;
    tick(4);
    rd_chk(4'h0, {ld_ctl, ld_addr[4:0]});
    rd_chk(4'h1, {2'h0, ld_addr[18:5]});
    m = {ld_ctl, ld_addr[4:0]};
    ld_ctl = ~ld_ctl;
    opcode = 3'h6;
    variant = 4'h4;
    local_mode = 1'b1;
    op_start = 1'b1;
    for (int k = 0; k < 8; k++) begin
      tick(1);
      op_start = 1'b0;
      ld_go = (k == 0);
      busy += int'(copy_busy === 1'b1);
    end
    check(64'(busy), 64'h4);
    check(desc, d);
    for (int k = 0; k < 4; k++)
      rd_chk(4'(3 + k), d[63 - 16 * k -: 16]);
    rd_chk(4'h0, m);
    report_and_stop();
  end
endmodule
